/* lvd_pkg.sv */
// Purpose: constants and types for the low-voltage detector control block
// Assumes: 8-bit processor data path, 16-bit byte addresses
// Notes: bit positions and reset values are shared by design and checks
package lvd_pkg;
    localparam logic [15:0] CTRL_ADDR = 16'hFFBE;
    localparam logic [15:0] THRESH_ADDR = 16'hFFBF;
    localparam logic [15:0] PORT12_ADDR = 16'hFF2C;
    localparam int ON_BIT = 7;
    localparam int SRC_BIT = 2;
    localparam int ACT_BIT = 1;
    localparam int FLAG_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] THRESH_RESET = 4'h0;
    localparam logic [7:0] PORT12_RESET = 8'hFF;
    localparam int PORT12_PINS = 5;

    // software-held control bits of the detector control register
    typedef struct packed {
        logic detectorOn;
        logic sourceSelect;
        logic actionSelect;
    } lvd_ctrl_type;

    // one processor write, byte or single bit
    typedef struct packed {
        logic byteWr;
        logic bitWr;
        logic [15:0] addr;
        logic [2:0] bitSel;
        logic bitVal;
        logic [7:0] data;
    } lvd_wr_type;
endpackage

/* lvd_control.sv */
// Purpose: register and control logic of the low-voltage detector
// Assumes: analog comparators outside, outputs asynchronous to clk
// Notes: rstFromMonitor qualifies rst when the monitor caused the reset
//
// Summary of operation
// - any reset except a monitor reset clears detector control register
// - detector_on bit seven enables detection
// - source_select bit two picks external pin
// - action_select bit one: irq or reset
// - read-only flag shows selected voltage below
// - monitor reset keeps three control bits
// - irq follows flag when on, action zero
// - both registers take bit and byte writes
// - any reset clears threshold select register
// - four-bit code picks sixteen descending thresholds
// - external pin uses fixed reference threshold
// - any reset sets port 12 direction ones
// - direction bit zero drives, one inputs
// - monitor reset sets low-voltage cause bit
`timescale 1ns/10ps
module lvd_control
    import lvd_pkg::*;
#(
    parameter int PINS = PORT12_PINS
) (
    input wire logic clk, // system clock, 20 MHz
    input wire logic rst, // synchronous reset, any source
    input wire logic rstFromMonitor, // this reset was raised by the monitor
    input wire lvd_wr_type wrReq, // processor write request
    input wire logic rdEn, // processor read strobe
    input wire logic [15:0] rdAddr, // processor read address
    output logic [7:0] rdData, // read data, one cycle after rdEn
    input wire logic supplyBelow, // supply comparator, async
    input wire logic externalBelow, // sense pin comparator, async
    output logic comparatorOn, // powers the comparator
    output logic sourceSelect, // 1 = external_sense_pin
    output logic [3:0] thresholdCode, // supply threshold, 0 highest
    output logic lowVoltageIrq, // low_voltage_irq request level
    output logic monitorResetReq, // internal reset request level
    output logic lowvoltResetCause, // low-voltage reset cause bit
    output logic [PINS-1:0] port12OeN // output buffer enable, low drives
);
    // refuse pin counts that the direction register cannot serve
    if (PINS < 1 || PINS > 8) begin : g_pins_bad
        $error("PINS must lie between 1 and 8");
    end

    lvd_ctrl_type ctrl_r, ctrl_nxt;
    logic [3:0] thresh_r, thresh_nxt;
    logic [7:0] port12_r, port12_nxt;
    logic flag_r, flag_nxt;
    logic cause_r, cause_nxt;
    logic supMeta_r, supSync_r, extMeta_r, extSync_r;
    logic [7:0] rd_r, rd_nxt;

    // merge a byte or single-bit write into a register image
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input lvd_wr_type w);
        logic [7:0] res;
        res = old;
        if (w.byteWr) begin
            res = w.data;
        end else if (w.bitWr) begin
            res[w.bitSel] = w.bitVal;
        end
        return res;
    endfunction

    // control register as software sees it
    function automatic logic [7:0] ctrlImage(input lvd_ctrl_type c,
                                             input logic f);
        logic [7:0] img;
        img = 8'h00;
        img[ON_BIT] = c.detectorOn;
        img[SRC_BIT] = c.sourceSelect;
        img[ACT_BIT] = c.actionSelect;
        img[FLAG_BIT] = f;
        return img;
    endfunction

    logic ctrlHit, threshHit, portHit;
    logic [7:0] ctrlNew;
    logic [7:0] threshNew;
    assign ctrlHit = (wrReq.byteWr | wrReq.bitWr) & wrReq.addr == CTRL_ADDR;
    assign threshHit = (wrReq.byteWr | wrReq.bitWr)
                       & wrReq.addr == THRESH_ADDR;
    assign portHit = (wrReq.byteWr | wrReq.bitWr) & wrReq.addr == PORT12_ADDR;
    assign ctrlNew = merge(ctrlImage(ctrl_r, flag_r), wrReq);
    assign threshNew = merge({4'h0, thresh_r}, wrReq);

    // two-stage synchronisers for the comparator outputs
    always_ff @(posedge clk) begin
        supMeta_r <= supplyBelow;
        supSync_r <= supMeta_r;
        extMeta_r <= externalBelow;
        extSync_r <= extMeta_r;
    end

    // next values of registers, flag and cause bit
    always_comb begin
        ctrl_nxt = ctrl_r;
        thresh_nxt = thresh_r;
        port12_nxt = port12_r;
        cause_nxt = cause_r | monitorResetReq;
        flag_nxt = ctrl_r.detectorOn
                   & (ctrl_r.sourceSelect ? extSync_r
                                          : supSync_r);
        if (ctrlHit) begin
            ctrl_nxt.detectorOn = ctrlNew[ON_BIT];
            ctrl_nxt.sourceSelect = ctrlNew[SRC_BIT];
            ctrl_nxt.actionSelect = ctrlNew[ACT_BIT];
        end
        if (threshHit) begin
            // upper four bits are never stored and read back as zero
            thresh_nxt = threshNew[3:0];
        end
        if (portHit) begin
            port12_nxt = merge(port12_r, wrReq);
        end
        if (rst) begin
            thresh_nxt = THRESH_RESET;
            port12_nxt = PORT12_RESET;
            flag_nxt = CTRL_RESET[FLAG_BIT];
            if (!rstFromMonitor) begin
                ctrl_nxt = '0;
                cause_nxt = 1'b0;
            end else begin
                ctrl_nxt = ctrl_r; // reset wins over a write
                cause_nxt = 1'b1;
            end
        end
    end

    // register stage, no logic here
    always_ff @(posedge clk) begin
        ctrl_r <= ctrl_nxt;
        thresh_r <= thresh_nxt;
        port12_r <= port12_nxt;
        flag_r <= flag_nxt;
        cause_r <= cause_nxt;
    end

    // read path, registered one cycle after the strobe
    always_comb begin
        rd_nxt = rd_r;
        if (rdEn) begin
            case (rdAddr)
                CTRL_ADDR: rd_nxt = ctrlImage(ctrl_r, flag_r);
                THRESH_ADDR: rd_nxt = {4'h0, thresh_r};
                PORT12_ADDR: rd_nxt = port12_r;
                default: rd_nxt = 8'h00;
            endcase
        end
        if (rst) begin
            rd_nxt = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        rd_r <= rd_nxt;
    end

    // outputs toward comparator, interrupt, reset and pins
    assign rdData = rd_r;
    assign comparatorOn = ctrl_r.detectorOn;
    assign sourceSelect = ctrl_r.sourceSelect;
    assign thresholdCode = thresh_r;
    assign lowVoltageIrq = ctrl_r.detectorOn & ~ctrl_r.actionSelect
                           & flag_r;
    assign monitorResetReq = ctrl_r.detectorOn & ctrl_r.actionSelect
                             & flag_r & ~rst;
    assign lowvoltResetCause = cause_r;
    assign port12OeN = port12_r[PINS-1:0];

    // checks
    // irq must track the selected synchronised comparator one edge later
    irq_follows_flag_a: assert property (
        @(posedge clk) disable iff (rst)
        (ctrl_r.detectorOn && !ctrl_r.actionSelect
         && $past(ctrl_r.detectorOn) && !$past(rst))
        |-> lowVoltageIrq
            == $past(ctrl_r.sourceSelect ? extSync_r : supSync_r))
        else $error("irq does not follow flag");
    flag_off_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl_r.detectorOn |=> !flag_r)
        else $error("flag set while detection off");
    sync_path_a: assert property (@(posedge clk) disable iff (rst)
        (ctrl_r.detectorOn && !ctrl_r.sourceSelect && !ctrlHit)
        |=> flag_r == $past(supSync_r))
        else $error("flag not from synchronised supply");
    ext_path_a: assert property (@(posedge clk) disable iff (rst)
        (ctrl_r.detectorOn && ctrl_r.sourceSelect && !ctrlHit)
        |=> flag_r == $past(extSync_r))
        else $error("flag not from external comparator");
    ctrl_reset_a: assert property (@(posedge clk)
        (rst && !rstFromMonitor) |=> ctrl_r == '0 && !flag_r)
        else $error("control not cleared by reset");
    keep_bits_a: assert property (@(posedge clk)
        (rst && rstFromMonitor) |=> $stable(ctrl_r) && lowvoltResetCause)
        else $error("monitor reset lost control bits");
    port_reset_a: assert property (@(posedge clk)
        rst |=> port12_r == PORT12_RESET && thresh_r == THRESH_RESET)
        else $error("port or threshold reset value wrong");
    reset_req_a: assert property (@(posedge clk) disable iff (rst)
        monitorResetReq |-> ctrl_r.actionSelect && !lowVoltageIrq)
        else $error("reset and irq asserted together");
    bit_write_a: assert property (@(posedge clk) disable iff (rst)
        (wrReq.bitWr && !wrReq.byteWr && wrReq.addr == THRESH_ADDR
         && wrReq.bitSel < 3'd4)
        |=> thresh_r[$past(wrReq.bitSel[1:0])] == $past(wrReq.bitVal))
        else $error("bit write to threshold lost");
    cause_set_a: assert property (@(posedge clk) disable iff (rst)
        monitorResetReq |=> lowvoltResetCause)
        else $error("cause bit not set");
    ctrl_write_a: assert property (@(posedge clk) disable iff (rst)
        (wrReq.byteWr && wrReq.addr == CTRL_ADDR)
        |=> ctrl_r.detectorOn == $past(wrReq.data[ON_BIT]))
        else $error("byte write to control lost");
endmodule

/* tb_top.sv */
// Purpose: self-checking bench for the low-voltage detector control block
// Assumes: inputs change at the falling edge, outputs sampled there too
// Notes: model keeps control, threshold and direction bytes as 8-bit vectors
`timescale 1ns/10ps
module tb_top;
    import lvd_pkg::*;
    logic clk, rst, rstFromMonitor, rdEn, supplyBelow, externalBelow;
    lvd_wr_type wrReq;
    logic [15:0] rdAddr;
    logic [7:0] rdData, mCtrl, mThr, mP12, v;
    logic comparatorOn, sourceSelect, lowVoltageIrq, monitorResetReq, f;
    logic lowvoltResetCause;
    logic [3:0] thresholdCode;
    logic [4:0] port12OeN;
    int n_errors = 0, checks_done = 0, seed = 74;
    localparam int SETTLE_CYCLES = 200; // ten microseconds at 50 ns

    lvd_control i_lvd_control (.clk(clk), .rst(rst),
        .rstFromMonitor(rstFromMonitor), .wrReq(wrReq), .rdEn(rdEn),
        .rdAddr(rdAddr), .rdData(rdData), .supplyBelow(supplyBelow),
        .externalBelow(externalBelow), .comparatorOn(comparatorOn),
        .sourceSelect(sourceSelect), .thresholdCode(thresholdCode),
        .lowVoltageIrq(lowVoltageIrq), .monitorResetReq(monitorResetReq),
        .lowvoltResetCause(lowvoltResetCause), .port12OeN(port12OeN));

    // free-running 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string nm, input logic [7:0] s, e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // one processor write, byte or single bit; model follows it
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      input logic bw, input logic [2:0] s);
        logic [7:0] cur;
        lvd_wr_type w;
        cur = (a == CTRL_ADDR) ? mCtrl : (a == THRESH_ADDR) ? mThr : mP12;
        if (bw) cur[s] = d[0];
        else cur = d;
        w = '0;
        w.byteWr = !bw;
        w.bitWr = bw;
        w.addr = a;
        w.bitSel = s;
        w.bitVal = d[0];
        w.data = d;
        @(negedge clk);
        wrReq = w;
        @(negedge clk);
        wrReq = '0;
        if (a == CTRL_ADDR) mCtrl = cur & 8'h86;
        else if (a == THRESH_ADDR) mThr = cur & 8'h0F;
        else if (a == PORT12_ADDR) mP12 = cur;
    endtask

    // read strobe, data checked one edge later under a mask
    task automatic rd(input logic [15:0] a, input logic [7:0] e, m);
        @(negedge clk);
        rdEn = 1'b1;
        rdAddr = a;
        @(negedge clk);
        rdEn = 1'b0;
        check("rdData", rdData & m, e & m);
    endtask

    // let the synchroniser settle, then compare control, threshold, the low five direction bits and every output except lowvoltResetCause
    task automatic chk_all();
        repeat (4) @(negedge clk);
        f = mCtrl[7] & (mCtrl[2] ? externalBelow : supplyBelow);
        rd(CTRL_ADDR, mCtrl | {7'h0, f}, 8'hFF);
        rd(THRESH_ADDR, mThr, 8'hFF);
        rd(PORT12_ADDR, mP12, 8'h1F);
        check("outs", {comparatorOn, sourceSelect,
            lowVoltageIrq, monitorResetReq, thresholdCode},
            {mCtrl[7], mCtrl[2], f & !mCtrl[1], f & mCtrl[1], mThr[3:0]});
        check("oeN", {3'h0, port12OeN}, {3'h0, mP12[4:0]});
    endtask

    // main sequence
    initial begin
        {rst, rstFromMonitor, rdEn, supplyBelow, externalBelow} = 5'b10000;
        rdAddr = '0;
        wrReq = '0;
        {mCtrl, mThr, mP12} = {8'h00, 8'h00, 8'hFF};
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk_all();
        rd(16'h1234, 8'h00, 8'hFF);
        // every threshold code, random direction bytes and bits
        for (int k = 0; k < 16; k++) begin
            v = 8'($random(seed));
            wr(THRESH_ADDR, 8'(k), 1'b0, 3'h0);
            wr(PORT12_ADDR, v, 1'b0, 3'h0);
            wr(PORT12_ADDR, {7'h0, v[0]}, 1'b1, v[3:1]);
            chk_all();
        end
        wr(THRESH_ADDR, 8'h01, 1'b1, 3'h2);
        wr(CTRL_ADDR, 8'hFF, 1'b0, 3'h0);
        chk_all();
        wr(CTRL_ADDR, 8'h00, 1'b0, 3'h0);
        wr(CTRL_ADDR, 8'h01, 1'b1, 3'h7);
        repeat (SETTLE_CYCLES) @(negedge clk);
        supplyBelow = 1'b1;
        chk_all();
        wr(CTRL_ADDR, 8'h01, 1'b1, 3'h2);
        chk_all();
        externalBelow = 1'b1;
        chk_all();
        wr(CTRL_ADDR, 8'h01, 1'b1, 3'h1);
        chk_all();
        // reset raised by the monitor keeps the three control bits
        @(negedge clk);
        {rst, rstFromMonitor, externalBelow} = 3'b110;
        @(negedge clk);
        {rst, rstFromMonitor} = 2'b00;
        {mThr, mP12} = {8'h00, 8'hFF};
        check("cause", {7'h0, lowvoltResetCause}, 8'h01);
        chk_all();
        wr(CTRL_ADDR, 8'h00, 1'b0, 3'h0);
        chk_all();
        wr(CTRL_ADDR, 8'h86, 1'b0, 3'h0);
        // any other reset also clears the control bits and the cause bit
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        mCtrl = 8'h00;
        check("cause", {7'h0, lowvoltResetCause}, 8'h00);
        chk_all();
        stop_test();
    end
endmodule
